/* File: common/adcctl_pkg.sv */
// Package with register map, field positions, types and timing of the converter control block.
package adcctl_pkg;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] ADC_CTRL_ADDR      = 8'h93;
  localparam logic [7:0] ADC_RES_LOW_ADDR   = 8'h94;
  localparam logic [7:0] ADC_RES_HIGH_ADDR  = 8'h95;
  localparam logic [7:0] ADC_CTRL_TWO_ADDR  = 8'h96;
  localparam logic [7:0] ADC_THRESH_ADDR    = 8'h97;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int PD_BIT      = 7;
  localparam int MODE_LSB    = 4;
  localparam int REF_BIT     = 3;
  localparam int RUN_BIT     = 2;
  localparam int CHAN_LSB    = 0;
  localparam int IE_BIT      = 7;
  localparam int IF_BIT      = 6;
  localparam int DIV_LSB     = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET     = 8'h80;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] THRESH_RESET   = 8'h00;
  localparam logic [9:0] RESULT_RESET   = 10'h000;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CONV_CYCLES   = 11;
  localparam int DIV_STEP      = 16;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ADCCTL_SINGLE = 2'h0,
    ADCCTL_CONT   = 2'h1,
    ADCCTL_STOP   = 2'h2,
    ADCCTL_RESET  = 2'h3
  } adcctl_mode_t;

  typedef enum logic [1:0] {
    ADCCTL_IN_PIN0  = 2'h0,
    ADCCTL_IN_PIN1  = 2'h1,
    ADCCTL_IN_RSSI  = 2'h2,
    ADCCTL_IN_EXTRF = 2'h3
  } adcctl_chan_t;

  typedef enum logic [1:0] {
    ADCCTL_REF_SUPPLY = 2'h0,
    ADCCTL_REF_INT    = 2'h1,
    ADCCTL_REF_EXT    = 2'h2
  } adcctl_ref_t;

  typedef struct packed {
    logic         power_down;
    adcctl_ref_t  ref_sel;
    adcctl_chan_t chan_sel;
    logic         start;
    logic         sample;
  } adcctl_ana_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcctl_sfr_t;

endpackage

/* File: rtl/adcctl_clkdiv.sv */
// Clock divider producing a one-cycle converter clock enable.
`timescale 1ns/1ps
module adcctl_clkdiv
  import adcctl_pkg::*;
#(
  parameter int DIV_W = 6
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  // Control
  input  wire logic             run_i,
  input  wire logic [DIV_W-1:0] div_sel_i,
  // Enable out
  output logic                  tick_o
);

  localparam int CNT_W = DIV_W + 4;

  if (DIV_W < 1 || DIV_W > 8) begin : g_div_w_check
    $error("adcctl_clkdiv: DIV_W out of range");
  end

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] limit;

  // Period is sixteen times the field plus one; the counter restarts
  // whenever run_i is low so the first tick lands a full period on.
  assign limit = CNT_W'({div_sel_i, 4'hF});

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !run_i) begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q  <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CNT_W'(1);
      tick_o <= 1'b0;
    end
  end

  chk_tick_single: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    tick_o |=> !tick_o) else $error("tick longer than one cycle");

endmodule // adcctl_clkdiv

/* File: rtl/adcctl_seq.sv */
// Conversion sequencer counting converter clocks within one conversion.
`timescale 1ns/1ps
module adcctl_seq
  import adcctl_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // Control
  input  wire logic active_i,
  input  wire logic tick_i,
  // Strobes
  output logic      start_o,
  output logic      sample_o,
  output logic      done_o
);

  logic [3:0] cnt_q;
  logic       busy_q;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      cnt_q    <= 4'h0;
      busy_q   <= 1'b0;
      start_o  <= 1'b0;
      sample_o <= 1'b0;
      done_o   <= 1'b0;
    end else begin
      start_o  <= 1'b0;
      sample_o <= 1'b0;
      done_o   <= 1'b0;
      if (tick_i) begin
        if (!busy_q) begin
          if (active_i) begin
            busy_q  <= 1'b1;
            cnt_q   <= 4'h1;
            start_o <= 1'b1;
          end
        end else if (cnt_q == 4'(CONV_CYCLES - 1)) begin
          // Eleventh tick closes this conversion; a following one begins
          // on the next tick so conversions repeat every eleven clocks.
          sample_o <= 1'b1;
          done_o   <= 1'b1;
          busy_q   <= 1'b0;
          cnt_q    <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end

  chk_done_count: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    done_o |-> $past(cnt_q) == 4'(CONV_CYCLES - 1))
    else $error("conversion not eleven clocks");

endmodule // adcctl_seq

/* File: rtl/adcctl_top.sv */
// Converter control registers, mode sequencing and result capture.
`timescale 1ns/1ps
// Contract
// - Power-down bit 7 holds converter off when one; resets to one.
// - Mode 00 does one conversion per start; interrupt only on threshold.
// - Mode 01 converts repeatedly, interrupt on each threshold hit.
// - Mode 10 converts repeatedly, interrupts and stops on first hit.
// - Mode 11 converts repeatedly, requests system reset on hit.
// - Reference bit 3 picks supply at zero, internal reference at one.
// - Writing run starts conversion; single mode clears run when done.
// - Clearing run in repeat modes finishes current conversion then halts.
// - Stopping mode clears run itself when it stops on threshold.
// - Channel field routes pin zero, pin one, strength pin, or extref.
// - Channel 11 ignores reference bit and uses external reference.
// - Low result byte read-only at 0x94, resets to zero.
// - High two bits latched on low byte read; upper bits zero.
// - Interrupt forwarded only when local and core enables set.
// - Hardware sets local flag, only software clears; shared flag too.
// - Converter clock is main clock over sixteen times field plus one.
// - Threshold holds when upper eight result bits reach threshold.
// - Each conversion takes eleven converter clocks, back to back.
// - Result registers survive system reset.
module adcctl_top
  import adcctl_pkg::*;
#(
  parameter int DIV_W = 6
) (
  // Clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  input  wire logic        por_nrst_i,
  // Special function register port
  input  wire adcctl_sfr_t sfr_i,
  output logic [7:0]       sfr_rdata_o,
  // Core interrupt controller
  input  wire logic        core_irq_enable_i,
  output logic             irq_o,
  output logic             sys_reset_req_o,
  // Analog core
  input  wire logic [9:0]  conv_data_i,
  output adcctl_ana_t      ana_o
);

  if (DIV_W != 6) begin : g_div_w_check
    $error("adcctl_top: divider field must be six bits");
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  logic         pd_q;
  adcctl_mode_t mode_q;
  logic         ref_q;
  logic         run_q;
  adcctl_chan_t chan_q;
  logic         ie_q;
  logic         if_q;
  logic [5:0]   div_q;
  logic [7:0]   thresh_q;
  logic [9:0]   result_q;
  logic [1:0]   high_q;

  logic wr_ctrl;
  logic wr_ctrl2;
  logic wr_thr;
  logic rd_low;
  logic tick;
  logic start;
  logic sample;
  logic done;
  logic [7:0] newest_hi;
  logic hit;
  logic active;
  logic conv_busy_q;
  logic div_run;

  function automatic logic sfr_wr(input adcctl_sfr_t s,
                                  input logic [7:0]  a);
    return s.wr && (s.addr == a);
  endfunction

  assign wr_ctrl  = sfr_wr(sfr_i, ADC_CTRL_ADDR);
  assign wr_ctrl2 = sfr_wr(sfr_i, ADC_CTRL_TWO_ADDR);
  assign wr_thr   = sfr_wr(sfr_i, ADC_THRESH_ADDR);
  assign rd_low   = sfr_i.rd && (sfr_i.addr == ADC_RES_LOW_ADDR);

  // ---------------------------------------------------------------------------
  // Threshold compare
  // ---------------------------------------------------------------------------
  assign newest_hi = conv_data_i[9:2];
  assign hit       = done && (newest_hi >= thresh_q);
  // A powered-down converter takes no conversions even with run set.
  assign active    = run_q && !pd_q;
  // The divider keeps ticking while a conversion is in flight, so clearing
  // run or powering down lets that conversion finish instead of freezing it.
  assign div_run   = active || start || conv_busy_q;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      conv_busy_q <= 1'b0;
    end else if (start) begin
      conv_busy_q <= 1'b1;
    end else if (done) begin
      conv_busy_q <= 1'b0;
    end
  end

  adcctl_clkdiv #(
    .DIV_W     (DIV_W)
  ) u_div (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .run_i     (div_run),
    .div_sel_i (div_q),
    .tick_o    (tick)
  );

  adcctl_seq u_seq (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .active_i  (active),
    .tick_i    (tick),
    .start_o   (start),
    .sample_o  (sample),
    .done_o    (done)
  );

  // ---------------------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      pd_q   <= CTRL_RESET[PD_BIT];
      mode_q <= adcctl_mode_t'(CTRL_RESET[MODE_LSB +: 2]);
      ref_q  <= CTRL_RESET[REF_BIT];
      chan_q <= adcctl_chan_t'(CTRL_RESET[CHAN_LSB +: 2]);
    end else if (wr_ctrl) begin
      pd_q   <= sfr_i.wdata[PD_BIT];
      mode_q <= adcctl_mode_t'(sfr_i.wdata[MODE_LSB +: 2]);
      ref_q  <= sfr_i.wdata[REF_BIT];
      chan_q <= adcctl_chan_t'(sfr_i.wdata[CHAN_LSB +: 2]);
    end
  end

  // Run bit. A software write wins over a hardware clear in the same cycle,
  // so a restart is never lost. Clearing it mid-conversion stops new starts
  // only; the sequencer finishes the conversion in flight.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      run_q <= CTRL_RESET[RUN_BIT];
    end else if (wr_ctrl) begin
      run_q <= sfr_i.wdata[RUN_BIT];
    end else if (done && mode_q == ADCCTL_SINGLE) begin
      run_q <= 1'b0;
    end else if (hit && mode_q == ADCCTL_STOP) begin
      run_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Control register two and threshold
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ie_q  <= CTRL_TWO_RESET[IE_BIT];
      div_q <= CTRL_TWO_RESET[DIV_LSB +: 6];
    end else if (wr_ctrl2) begin
      ie_q  <= sfr_i.wdata[IE_BIT];
      div_q <= sfr_i.wdata[DIV_LSB +: 6];
    end
  end

  // Interrupt flag: hardware set wins over a software clear.
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      if_q <= CTRL_TWO_RESET[IF_BIT];
    end else if (hit && mode_q != ADCCTL_RESET) begin
      if_q <= 1'b1;
    end else if (wr_ctrl2) begin
      if_q <= sfr_i.wdata[IF_BIT];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      thresh_q <= THRESH_RESET;
    end else if (wr_thr) begin
      thresh_q <= sfr_i.wdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Result capture
  // ---------------------------------------------------------------------------
  // Only power-on reset clears the result so that a sample that triggered a
  // system reset can still be read afterwards.
  always_ff @(posedge sys_clk_i) begin
    if (!por_nrst_i) begin
      result_q <= RESULT_RESET;
      high_q   <= RESULT_RESET[9:8];
    end else begin
      if (done) begin
        result_q <= conv_data_i;
      end
      if (rd_low) begin
        high_q <= result_q[9:8];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      irq_o           <= 1'b0;
      sys_reset_req_o <= 1'b0;
    end else begin
      irq_o           <= if_q && ie_q && core_irq_enable_i;
      sys_reset_req_o <= hit && mode_q == ADCCTL_RESET;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      ana_o <= '{power_down: 1'b1, ref_sel: ADCCTL_REF_SUPPLY,
                 chan_sel: ADCCTL_IN_PIN0, start: 1'b0, sample: 1'b0};
    end else begin
      ana_o.power_down <= pd_q;
      ana_o.chan_sel   <= chan_q;
      if (chan_q == ADCCTL_IN_EXTRF) begin
        ana_o.ref_sel <= ADCCTL_REF_EXT;
      end else if (ref_q) begin
        ana_o.ref_sel <= ADCCTL_REF_INT;
      end else begin
        ana_o.ref_sel <= ADCCTL_REF_SUPPLY;
      end
      ana_o.start  <= start;
      ana_o.sample <= sample;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      case (sfr_i.addr)
        ADC_CTRL_ADDR:
          sfr_rdata_o <= {pd_q, 1'b0, mode_q, ref_q, run_q, chan_q};
        ADC_RES_LOW_ADDR:  sfr_rdata_o <= result_q[7:0];
        ADC_RES_HIGH_ADDR: sfr_rdata_o <= {6'h00, high_q};
        ADC_CTRL_TWO_ADDR: sfr_rdata_o <= {ie_q, if_q, div_q};
        ADC_THRESH_ADDR:   sfr_rdata_o <= thresh_q;
        default:           sfr_rdata_o <= 8'h00;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_single_clears_run: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (done && mode_q == ADCCTL_SINGLE && !wr_ctrl) |=> !run_q)
    else $error("single mode left run set");
  chk_stop_on_hit: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (hit && mode_q == ADCCTL_STOP && !wr_ctrl) |=> !run_q)
    else $error("stopping mode kept running");
  chk_flag_set: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (hit && mode_q != ADCCTL_RESET) |=> if_q)
    else $error("flag not set on threshold");
  chk_reset_req: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    (hit && mode_q == ADCCTL_RESET)
      |=> sys_reset_req_o && (!if_q || $past(if_q)))
    else $error("reset request missing");
  chk_irq_gate: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    irq_o |-> $past(ie_q) && $past(core_irq_enable_i))
    else $error("irq without enables");
  chk_high_latch: assert property (@(posedge sys_clk_i)
    disable iff (!por_nrst_i)
    rd_low |=> high_q == $past(result_q[9:8]))
    else $error("high bits not latched");
  chk_extref: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    chan_q == ADCCTL_IN_EXTRF |=> ana_o.ref_sel == ADCCTL_REF_EXT)
    else $error("external reference not used");
  chk_pd_idle: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    pd_q |=> !start)
    else $error("conversion started in power down");
  chk_start_idle: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    start |-> !conv_busy_q)
    else $error("conversion started while one in flight");
  chk_high_zero: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    sfr_i.addr == ADC_RES_HIGH_ADDR |=> sfr_rdata_o[7:2] == 6'h00)
    else $error("high register upper bits set");
  chk_req_mode: assert property (@(posedge sys_clk_i)
    disable iff (!nrst_i)
    sys_reset_req_o |-> $past(mode_q) == ADCCTL_RESET)
    else $error("reset request outside reset mode");

  cov_single: cover property (@(posedge sys_clk_i)
    done && mode_q == ADCCTL_SINGLE);
  cov_cont_hit: cover property (@(posedge sys_clk_i)
    hit && mode_q == ADCCTL_CONT);
  cov_stop_hit: cover property (@(posedge sys_clk_i)
    hit && mode_q == ADCCTL_STOP);
  cov_reset_hit: cover property (@(posedge sys_clk_i) sys_reset_req_o);

endmodule // adcctl_top

/* File: verification/adcctl_analog_model.sv */
// Behavioural model of the analog converter core and its input multiplexer.
`timescale 1ns/1ps
module adcctl_analog_model
  import adcctl_pkg::*;
(
  // Control from the block
  input  wire logic        sys_clk_i,
  input  wire adcctl_ana_t ana_i,
  // Analog inputs, given as ideal codes
  input  wire logic [9:0]  pin0_i,
  input  wire logic [9:0]  pin1_i,
  input  wire logic [9:0]  rssi_i,
  // Result to the block
  output logic      [9:0]  data_o
);
  // ---------------------------------------------------------------------------
  // Sample and hold
  // ---------------------------------------------------------------------------
  // A powered-down core has no valid code, so the output churns every cycle.
  // The input is held at the start strobe, so the code stands long before
  // the block captures it as the conversion ends.
  initial data_o = 10'h2A5;
  always @(posedge sys_clk_i) begin
    if (ana_i.power_down) begin
      data_o <= ~data_o;
    end else if (ana_i.start) begin
      case (ana_i.chan_sel)
        ADCCTL_IN_PIN1: data_o <= pin1_i;
        ADCCTL_IN_RSSI: data_o <= rssi_i;
        default:        data_o <= pin0_i;
      endcase
    end
  end
endmodule // adcctl_analog_model

/* File: verification/adcctl_top_test.sv */
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
module adcctl_top_test
  import adcctl_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        sys_clk_i  = 1'b0;
  logic        nrst_i     = 1'b0;
  logic        por_nrst_i = 1'b0;
  logic        core_en    = 1'b0;
  adcctl_sfr_t sfr        = '0;
  logic [9:0]  pin0       = 10'h000;
  logic [9:0]  pin1       = 10'h000;
  logic [9:0]  rssi       = 10'h000;
  logic [7:0]  rdata;
  logic [7:0]  d;
  logic        irq;
  logic        rst_req;
  logic [9:0]  conv;
  adcctl_ana_t ana;
  int          bad_count  = 0;
  int          n_compared = 0;
  int          seed       = 29;
  int          cyc        = 0;
  int          n_start    = 0;
  int          n_req      = 0;
  int          last_st    = 0;
  int          gap        = 0;
  int          n_sample   = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  adcctl_top i_adcctl_top (
    .sys_clk_i         (sys_clk_i),
    .nrst_i            (nrst_i),
    .por_nrst_i        (por_nrst_i),
    .sfr_i             (sfr),
    .sfr_rdata_o       (rdata),
    .core_irq_enable_i (core_en),
    .irq_o             (irq),
    .sys_reset_req_o   (rst_req),
    .conv_data_i       (conv),
    .ana_o             (ana)
  );

  adcctl_analog_model i_adcctl_analog_model (
    .sys_clk_i (sys_clk_i),
    .ana_i     (ana),
    .pin0_i    (pin0),
    .pin1_i    (pin1),
    .rssi_i    (rssi),
    .data_o    (conv)
  );

  // ---------------------------------------------------------------------------
  // Monitor and timeout
  // ---------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (ana.start === 1'b1) begin
      n_start <= n_start + 1;
      gap     <= cyc - last_st;
      last_st <= cyc;
    end
    if (ana.sample === 1'b1) begin
      n_sample <= n_sample + 1;
    end
    if (rst_req === 1'b1) begin
      n_req <= n_req + 1;
    end
    if (cyc == 60000) begin
      bad_count++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------------
  // Tasks and functions
  // ---------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk_i) sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge sys_clk_i) sfr <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge sys_clk_i) sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk_i) sfr <= '0;
    #1 v = rdata;
  endtask

  task automatic cmp8(input string n, input logic [7:0] e,
                      input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cmp_cnt(input string n, input int e, input int g);
    n_compared++;
    if (g != e) begin
      bad_count++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic chk(input string n, input logic [7:0] a,
                     input logic [7:0] e);
    rd(a, d);
    cmp8(n, e, d);
  endtask

  // The run bit is polled, so a stuck bit ends in a mismatch, not a hang.
  task automatic wait_idle();
    d = 8'h04;
    for (int k = 0; k < 1000 && d[RUN_BIT] !== 1'b0; k++) begin
      rd(ADC_CTRL_ADDR, d);
    end
    cmp8("run clear", 8'h00, d[RUN_BIT]);
  endtask

  task automatic wait_for(ref int c, input int t);
    for (int k = 0; k < 5000 && c < t; k++) begin
      @(posedge sys_clk_i);
    end
    #1;
    if (c < t) begin
      bad_count++;
      $display("ERROR wait expected %0d seen %0d", t, c);
    end
  endtask

  function automatic logic hit(input logic [9:0] v, input logic [7:0] t);
    return v[9:2] >= t;
  endfunction

  function automatic adcctl_ref_t exp_ref(input logic [1:0] c,
                                          input logic r);
    if (c == 2'h3) begin
      return ADCCTL_REF_EXT;
    end
    return r ? ADCCTL_REF_INT : ADCCTL_REF_SUPPLY;
  endfunction

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [9:0]  v;
    logic [7:0]  t;
    logic [1:0]  dv;
    logic [1:0]  hi;
    logic        ie;
    logic        rf;
    int          s0;
    hi = 2'h0;
    repeat (12) @(posedge sys_clk_i);
    nrst_i     <= 1'b1;
    por_nrst_i <= 1'b1;
    chk("ctrl reset", ADC_CTRL_ADDR, 8'h80);
    chk("low reset", ADC_RES_LOW_ADDR, 8'h00);
    chk("high reset", ADC_RES_HIGH_ADDR, 8'h00);
    chk("ctrl2 reset", ADC_CTRL_TWO_ADDR, 8'h00);
    chk("unmapped", 8'h90, 8'h00);
    wr(ADC_RES_LOW_ADDR, 8'hFF);
    chk("low write", ADC_RES_LOW_ADDR, 8'h00);
    s0 = n_start;
    wr(ADC_CTRL_ADDR, 8'h84);
    repeat (300) @(posedge sys_clk_i);
    cmp8("pd pin", 8'h01, ana.power_down);
    cmp_cnt("pd starts", 0, n_start - s0);
    $display("test reset and power-down done");
    for (int c = 0; c < 4; c++) begin
      r  = $random(seed);
      dv = r[1:0];
      ie = r[2];
      rf = r[3];
      t  = (c == 0) ? 8'h00 : r[31:24];
      v  = (c == 1) ? r[23:14] : ((c == 2) ? ~r[13:4] : r[13:4]);
      @(posedge sys_clk_i);
      pin0    <= r[13:4];
      pin1    <= r[23:14];
      rssi    <= ~r[13:4];
      core_en <= (c != 3);
      wr(ADC_CTRL_TWO_ADDR, {ie, 1'b0, 4'h0, dv});
      wr(ADC_THRESH_ADDR, t);
      s0 = n_start;
      wr(ADC_CTRL_ADDR, {4'h0, rf, 1'b1, c[1:0]});
      wait_idle();
      repeat (DIV_STEP * 8) @(posedge sys_clk_i);
      cmp_cnt("single starts", 1, n_start - s0);
      cmp8("ref", exp_ref(c[1:0], rf), ana.ref_sel);
      cmp8("chan", c[1:0], ana.chan_sel);
      chk("flag", ADC_CTRL_TWO_ADDR, {ie, hit(v, t), 4'h0, dv});
      cmp8("irq", ie & hit(v, t) & (c != 3), irq);
      chk("high stale", ADC_RES_HIGH_ADDR, hi);
      chk("low", ADC_RES_LOW_ADDR, v[7:0]);
      chk("high", ADC_RES_HIGH_ADDR, v[9:8]);
      hi = v[9:8];
      // The core-level flag lives outside; the local flag is cleared last.
      wr(ADC_CTRL_TWO_ADDR, {ie, 1'b0, 4'h0, dv});
      repeat (2) @(posedge sys_clk_i);
      #1 cmp8("irq clear", 8'h00, irq);
    end
    $display("test single conversions done");
    r  = $random(seed);
    dv = r[1:0];
    @(posedge sys_clk_i);
    pin0    <= 10'h3FF;
    core_en <= 1'b1;
    wr(ADC_CTRL_TWO_ADDR, {2'b10, 4'h0, dv});
    wr(ADC_THRESH_ADDR, 8'hFF);
    s0 = n_start;
    wr(ADC_CTRL_ADDR, 8'h14);
    wait_for(n_start, s0 + 3);
    cmp_cnt("period", CONV_CYCLES * DIV_STEP * (dv + 1), gap);
    wr(ADC_CTRL_TWO_ADDR, {2'b10, 4'h0, dv});
    wait_for(n_start, s0 + 5);
    chk("flag again", ADC_CTRL_TWO_ADDR, {2'b11, 4'h0, dv});
    wr(ADC_CTRL_ADDR, 8'h10);
    repeat (CONV_CYCLES * DIV_STEP * 5) @(posedge sys_clk_i);
    s0 = n_start;
    repeat (CONV_CYCLES * DIV_STEP * 8) @(posedge sys_clk_i);
    cmp_cnt("halted", 0, n_start - s0);
    cmp_cnt("finished", n_start, n_sample);
    chk("run off", ADC_CTRL_ADDR, 8'h10);
    $display("test continuous mode done");
    @(posedge sys_clk_i);
    pin0 <= 10'h26F;
    wr(ADC_THRESH_ADDR, 8'h9C);
    wr(ADC_CTRL_TWO_ADDR, {2'b00, 4'h0, dv});
    s0 = n_start;
    wr(ADC_CTRL_ADDR, 8'h24);
    wait_for(n_start, s0 + 2);
    chk("below", ADC_CTRL_TWO_ADDR, {2'b00, 4'h0, dv});
    @(posedge sys_clk_i);
    pin0 <= 10'h270;
    wait_idle();
    chk("stop flag", ADC_CTRL_TWO_ADDR, {2'b01, 4'h0, dv});
    chk("stop low", ADC_RES_LOW_ADDR, 8'h70);
    s0 = n_start;
    repeat (CONV_CYCLES * DIV_STEP * 8) @(posedge sys_clk_i);
    cmp_cnt("stopped", 0, n_start - s0);
    $display("test stopping mode done");
    r = $random(seed);
    v = r[9:0];
    wr(ADC_THRESH_ADDR, 8'h00);
    wr(ADC_CTRL_TWO_ADDR, {2'b00, 4'h0, dv});
    @(posedge sys_clk_i);
    pin0 <= v;
    s0 = n_req;
    wr(ADC_CTRL_ADDR, 8'h34);
    wait_for(n_req, s0 + 1);
    cmp_cnt("reset req", s0 + 1, n_req);
    chk("no flag", ADC_CTRL_TWO_ADDR, {2'b00, 4'h0, dv});
    @(posedge sys_clk_i) nrst_i <= 1'b0;
    repeat (2) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    chk("ctrl after", ADC_CTRL_ADDR, 8'h80);
    chk("low kept", ADC_RES_LOW_ADDR, v[7:0]);
    chk("high kept", ADC_RES_HIGH_ADDR, v[9:8]);
    $display("test reset-generating mode done");
    wrap_up();
  end
endmodule // adcctl_top_test
